// ---- rtl/zqo_defines.vh ----
// Constants for the ZQ calibration and on-die termination block
`ifndef ZQO_DEFINES_VH
`define ZQO_DEFINES_VH

// Register bus shape
`define ZQO_AW 8
`define ZQO_DW 32

// Register byte addresses
`define ZQO_ADDR_CFG 8'h00
`define ZQO_ADDR_ZQINIT 8'h04
`define ZQO_ADDR_ZQOPER 8'h08
`define ZQO_ADDR_ZQCS 8'h0C
`define ZQO_ADDR_STATUS 8'h10
`define ZQO_ADDR_CODES 8'h14

// Configuration fields: mode register image
`define ZQO_CFG_RTT_NOM_LSB 0
`define ZQO_CFG_RTT_WR_LSB 3
`define ZQO_CFG_CWL_LSB 5
`define ZQO_CFG_AL_LSB 9
`define ZQO_CFG_DLL_ON_BIT 13
`define ZQO_CFG_PD_DLL_BIT 14
`define ZQO_CFG_W 15

// Configuration reset values
`define ZQO_RST_RTT_NOM 3'h0
`define ZQO_RST_RTT_WR 2'h0
`define ZQO_RST_CWL 4'h5
`define ZQO_RST_AL 4'h0
`define ZQO_RST_DLL_ON 1'h1
`define ZQO_RST_PD_DLL 1'h0

// Calibration windows in CK cycles
`define ZQO_CNT_W 16
`define ZQO_RST_ZQINIT 16'h0200
`define ZQO_RST_ZQOPER 16'h0100
`define ZQO_RST_ZQCS 16'h0040

// Impedance code width and its value out of reset
`define ZQO_CODE_W 6
`define ZQO_RST_CODE 6'h20

// Termination latency pipeline depth (covers CWL + AL up to 33)
`define ZQO_PIPE_W 32

`endif

// ---- rtl/zqo_core.v ----
// ZQ calibration command handling and synchronous on-die termination control
`timescale 1ns/1ps
`default_nettype none
`include "zqo_defines.vh"

// Contract
// - ZQCL starts long calibration, any time; code takes it only when idle, CKE high and outside self-refresh
// - Finished calibration updates driver and termination codes
// - First ZQCL gets tZQinit, later tZQoper
// - ZQCS finishes within tZQCS, steps each cycle
// - ZQ current path off once calibrated
// - No calibration after self-refresh exit unless commanded
// - Self-refresh forces termination off, pin ignored
// - Termination enabled only by nonzero RTT bits
// - ODT low off; high on unless disabled
// - No read or write decode decides termination; refresh decode turns it off only through self-refresh
// - Synchronous mode whenever DLL on and locked
// - Termination follows ODT after WL minus two
// - Latency equals CWL plus AL minus two
module zqo_core (
  // Clock, reset, enable
  input wire sys_clk,
  input wire rst_b,
  input wire clk_en,
  // Device pins from the memory controller
  input wire ck,
  input wire cke,
  input wire cs_b,
  input wire ras_b,
  input wire cas_b,
  input wire we_b,
  input wire addr10,
  input wire odt,
  // Analog comparator on the ZQ reference leg
  input wire zq_cmp,
  // Register port
  input wire [`ZQO_AW-1:0] reg_addr,
  input wire [`ZQO_DW-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`ZQO_DW-1:0] reg_rdata,
  // Impedance and termination controls to the IO ring
  output reg term_on,
  output reg [2:0] rtt_sel,
  output reg [`ZQO_CODE_W-1:0] ron_code,
  output reg [`ZQO_CODE_W-1:0] rtt_code,
  output reg zq_path_en,
  output reg zq_busy
);

  // Calibration states
  localparam CAL_IDLE = 2'b00;
  localparam CAL_LONG = 2'b01;
  localparam CAL_SHORT = 2'b10;

  // Pin bundle positions inside the synchroniser
  localparam PIN_W = 9;

  reg [PIN_W-1:0] pin_s1;
  reg [PIN_W-1:0] pin_s2;
  reg ck_last;
  reg [`ZQO_CFG_W-1:0] cfg;
  reg [`ZQO_CNT_W-1:0] win_init;
  reg [`ZQO_CNT_W-1:0] win_oper;
  reg [`ZQO_CNT_W-1:0] win_short;
  reg [1:0] cal_st;
  reg [1:0] next_cal_st;
  reg [`ZQO_CNT_W-1:0] cal_cnt;
  reg [`ZQO_CNT_W-1:0] next_cal_cnt;
  reg first_done;
  reg [`ZQO_CODE_W-1:0] work_code;
  reg self_ref;
  reg cke_prev;
  reg [`ZQO_PIPE_W-1:0] odt_pipe;

  wire ck_s;
  wire cke_s;
  wire cs_s;
  wire ras_s;
  wire cas_s;
  wire we_s;
  wire a10_s;
  wire odt_s;
  wire cmp_s;
  wire ck_rise;
  wire cmd_zq;
  wire cmd_ref;
  wire zq_long;
  wire zq_short;
  wire done;
  wire [2:0] rtt_nom;
  wire [1:0] rtt_wr;
  wire [3:0] cwl;
  wire [3:0] al;
  wire dll_on;
  wire pd_dll;
  wire odt_enable;
  wire sync_mode;
  wire [4:0] odt_lat;
  wire next_term;

  // CK is sampled as a plain level, so the system clock must run several
  // times faster than CK; pins must settle well before each CK rise.
  // Two-flop synchroniser on every pin; only stage two is read
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1 <= {PIN_W{1'b0}};
      pin_s2 <= {PIN_W{1'b0}};
      ck_last <= 1'b0;
    end else if (clk_en) begin
      pin_s1 <= {zq_cmp, odt, addr10, we_b, cas_b, ras_b, cs_b, cke, ck};
      pin_s2 <= pin_s1;
      ck_last <= pin_s2[0];
    end
  end

  assign ck_s = pin_s2[0];
  assign cke_s = pin_s2[1];
  assign cs_s = pin_s2[2];
  assign ras_s = pin_s2[3];
  assign cas_s = pin_s2[4];
  assign we_s = pin_s2[5];
  assign a10_s = pin_s2[6];
  assign odt_s = pin_s2[7];
  assign cmp_s = pin_s2[8];

  // Rising CK edge seen by the system clock; pins are registered here
  assign ck_rise = ck_s & ~ck_last;

  // Command decode; only ZQ and refresh matter to this block
  assign cmd_zq = ~cs_s & ras_s & cas_s & ~we_s;
  assign cmd_ref = ~cs_s & ~ras_s & ~cas_s & we_s;
  assign zq_long = ck_rise & cmd_zq & a10_s & cke_s & ~self_ref;
  assign zq_short = ck_rise & cmd_zq & ~a10_s & cke_s & ~self_ref;

  // Mode register image fields
  assign rtt_nom = cfg[`ZQO_CFG_RTT_NOM_LSB +: 3];
  assign rtt_wr = cfg[`ZQO_CFG_RTT_WR_LSB +: 2];
  assign cwl = cfg[`ZQO_CFG_CWL_LSB +: 4];
  assign al = cfg[`ZQO_CFG_AL_LSB +: 4];
  assign dll_on = cfg[`ZQO_CFG_DLL_ON_BIT];
  assign pd_dll = cfg[`ZQO_CFG_PD_DLL_BIT];

  // Any nonzero RTT bit enables termination
  assign odt_enable = (|rtt_nom) | (|rtt_wr);

  // DLL locked: CKE high, or power-down with DLL kept on
  assign sync_mode = dll_on & ~self_ref & (cke_s | pd_dll);

  // Software keeps CWL + AL within 3..33; below two the stage index wraps.
  // Latency CWL + AL - 2; CWL is not checked, so a sum below two wraps
  assign odt_lat = ({1'b0, cwl} + {1'b0, al}) - 5'h02;

  // Writes take effect on the next cycle with no shadow copy, so a mode
  // change lands at once even while termination is switched on.
  // Register writes; the mode image steers termination and latency
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= {`ZQO_RST_PD_DLL, `ZQO_RST_DLL_ON, `ZQO_RST_AL, `ZQO_RST_CWL,
              `ZQO_RST_RTT_WR, `ZQO_RST_RTT_NOM};
      win_init <= `ZQO_RST_ZQINIT;
      win_oper <= `ZQO_RST_ZQOPER;
      win_short <= `ZQO_RST_ZQCS;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        `ZQO_ADDR_CFG: cfg <= reg_wdata[`ZQO_CFG_W-1:0];
        `ZQO_ADDR_ZQINIT: win_init <= reg_wdata[`ZQO_CNT_W-1:0];
        `ZQO_ADDR_ZQOPER: win_oper <= reg_wdata[`ZQO_CNT_W-1:0];
        `ZQO_ADDR_ZQCS: win_short <= reg_wdata[`ZQO_CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads give zero
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= {`ZQO_DW{1'b0}};
    end else if (clk_en) begin
      if (reg_rd) begin
        case (reg_addr)
          `ZQO_ADDR_CFG: reg_rdata <= {{(`ZQO_DW-`ZQO_CFG_W){1'b0}}, cfg};
          `ZQO_ADDR_ZQINIT: reg_rdata <= {{(`ZQO_DW-`ZQO_CNT_W){1'b0}}, win_init};
          `ZQO_ADDR_ZQOPER: reg_rdata <= {{(`ZQO_DW-`ZQO_CNT_W){1'b0}}, win_oper};
          `ZQO_ADDR_ZQCS: reg_rdata <= {{(`ZQO_DW-`ZQO_CNT_W){1'b0}}, win_short};
          `ZQO_ADDR_STATUS: reg_rdata <= {24'h000000, cal_st, sync_mode, zq_path_en,
                                           self_ref, term_on, first_done, zq_busy};
          `ZQO_ADDR_CODES: reg_rdata <= {8'h00, 2'h0, work_code, 2'h0, rtt_code,
                                          2'h0, ron_code};
          default: reg_rdata <= {`ZQO_DW{1'b0}};
        endcase
      end else begin
        reg_rdata <= {`ZQO_DW{1'b0}};
      end
    end
  end

  // A count of zero behaves as one, so a cleared window still ends cleanly
  // after a single CK edge instead of wrapping to a very long wait.
  // Calibration window ends on the CK edge where the count reaches one
  assign done = ck_rise & (cal_st != CAL_IDLE) & (cal_cnt <= 16'h0001);

  // Calibration sequencer: picks the window, counts it down in CK cycles
  always @* begin
    next_cal_st = cal_st;
    next_cal_cnt = cal_cnt;
    case (cal_st)
      CAL_IDLE: begin
        if (zq_long) begin
          next_cal_st = CAL_LONG;
          // First long command after reset gets the init window
          next_cal_cnt = first_done ? win_oper : win_init;
        end else if (zq_short) begin
          next_cal_st = CAL_SHORT;
          next_cal_cnt = win_short;
        end
      end
      CAL_LONG, CAL_SHORT: begin
        if (done) begin
          next_cal_st = CAL_IDLE;
          next_cal_cnt = {`ZQO_CNT_W{1'b0}};
        end else if (ck_rise) begin
          next_cal_cnt = cal_cnt - 16'h0001;
        end
      end
      default: begin
        next_cal_st = CAL_IDLE;
        next_cal_cnt = {`ZQO_CNT_W{1'b0}};
      end
    endcase
  end

  // Dropping rather than queueing a mid-window command keeps the sequencer
  // small; a controller that honours the quiet time never loses one.
  // Sequencer state; commands arriving mid-window are ignored, the channel is quiet
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_st <= CAL_IDLE;
      cal_cnt <= {`ZQO_CNT_W{1'b0}};
      first_done <= 1'b0;
      zq_busy <= 1'b0;
      zq_path_en <= 1'b0;
    end else if (clk_en) begin
      cal_st <= next_cal_st;
      cal_cnt <= next_cal_cnt;
      zq_busy <= (next_cal_st != CAL_IDLE);
      // Reference current flows only while calibrating
      zq_path_en <= (next_cal_st != CAL_IDLE);
      if (done && cal_st == CAL_LONG) begin
        first_done <= 1'b1;
      end
    end
  end

  // Calibration engine: one code step per CK edge toward the comparator.
  // A single step per cycle keeps a short command within its correction bound.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      work_code <= `ZQO_RST_CODE;
      ron_code <= `ZQO_RST_CODE;
      rtt_code <= `ZQO_RST_CODE;
    end else if (clk_en) begin
      // Step the code each CK while a window runs
      if (ck_rise && cal_st != CAL_IDLE && !done) begin
        if (cmp_s && work_code != {`ZQO_CODE_W{1'b1}}) begin
          work_code <= work_code + 6'h01;
        end else if (!cmp_s && work_code != {`ZQO_CODE_W{1'b0}}) begin
          work_code <= work_code - 6'h01;
        end
      end
      // Transfer the result to the driver and termination legs
      if (done) begin
        ron_code <= work_code;
        rtt_code <= work_code;
      end
    end
  end

  // Power-down entered with a deselect never sets this flag; only a refresh
  // registered while CKE falls does.
  // Self-refresh tracking: entered by refresh with CKE low, left when CKE rises
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      self_ref <= 1'b0;
      cke_prev <= 1'b1;
    end else if (clk_en && ck_rise) begin
      cke_prev <= cke_s;
      if (!self_ref && cmd_ref && cke_prev && !cke_s) begin
        self_ref <= 1'b1;
      end else if (self_ref && cke_s) begin
        // Exit starts no calibration by itself
        self_ref <= 1'b0;
      end
    end
  end

  // The pipeline is deeper than any legal latency so an old pulse ages out;
  // changing the latency while ODT is high may shorten or stretch a pulse.
  // ODT latency pipeline, one stage per CK edge.
  // Only the pin level is fed in; read and write decode plays no part.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      odt_pipe <= {`ZQO_PIPE_W{1'b0}};
    end else if (clk_en && ck_rise) begin
      // Pin ignored in self-refresh and outside synchronous mode
      odt_pipe <= {odt_pipe[`ZQO_PIPE_W-2:0], odt_s & sync_mode};
    end
  end

  // Stage index odt_lat holds ODT sampled that many CK edges earlier
  // High pin turns termination on only when enabled by the mode bits
  assign next_term = odt_pipe[odt_lat] & odt_enable & ~self_ref;

  // Registered so the IO ring sees one clean level, at the cost of one
  // system clock after the detected CK edge.
  // Termination switch and selected nominal value
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      term_on <= 1'b0;
      rtt_sel <= 3'h0;
    end else if (clk_en) begin
      term_on <= next_term;
      rtt_sel <= rtt_nom;
    end
  end

endmodule // zqo_core

`default_nettype wire

// ---- verification/zqo_asserts.sv ----
// Checker for the ZQ calibration and termination block
`timescale 1ns/1ps
`default_nettype none
`include "zqo_defines.vh"
module zqo_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Device pins
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic odt,
  // Register port
  input wire logic [`ZQO_AW-1:0] reg_addr,
  input wire logic [`ZQO_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`ZQO_DW-1:0] reg_rdata,
  // Outputs to the IO ring
  input wire logic term_on,
  input wire logic [2:0] rtt_sel,
  input wire logic [`ZQO_CODE_W-1:0] ron_code,
  input wire logic [`ZQO_CODE_W-1:0] rtt_code,
  input wire logic zq_path_en,
  input wire logic zq_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [8:0] odt_low;
  // Cycles with ODT low; saturates so a long idle never wraps
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) odt_low <= 9'h000;
    else if (odt) odt_low <= 9'h000;
    else if (odt_low != 9'h1FF) odt_low <= odt_low + 9'h001;
  end
  a_path_busy: assert property (zq_path_en == zq_busy)
    else $error("zq path enable differs from busy");
  a_codes_hold: assert property (!$fell(zq_busy) |-> $stable(ron_code) && $stable(rtt_code))
    else $error("codes moved outside window end");
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero after idle cycle");
  a_odt_off: assert property (odt_low > 9'h140 |-> !term_on)
    else $error("termination on with ODT long low");
  a_busy_cause: assert property ($rose(zq_busy) |-> $past(!cs_b && ras_b && cas_b && !we_b && cke, 5))
    else $error("busy without ZQ command");
  a_busy_min: assert property ($fell(zq_busy) |-> $past(zq_busy, 6))
    else $error("calibration window too short");
  a_rtt_copy: assert property (reg_wr && reg_addr == `ZQO_ADDR_CFG |-> ##2 rtt_sel == $past(reg_wdata[2:0], 2))
    else $error("rtt select not copied");
  a_ck_aligned: assert property ($changed(term_on) || $changed(zq_busy) |-> $past(ck, 2))
    else $error("output change not after CK rise");
endmodule // zqo_asserts
bind zqo_core zqo_asserts zqo_asserts_i (.sys_clk, .rst_b, .ck, .cke, .cs_b, .ras_b, .cas_b,
  .we_b, .odt, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .term_on, .rtt_sel,
  .ron_code, .rtt_code, .zq_path_en, .zq_busy);
`default_nettype wire

// ---- verification/zqo_ctrl_model.sv ----
// Memory controller model driving CK, commands, CKE and ODT
`timescale 1ns/1ps
`default_nettype none
module zqo_ctrl_model (
  // Clock and command pins
  output var logic ck,
  output var logic cke,
  output var logic cs_b,
  output var logic ras_b,
  output var logic cas_b,
  output var logic we_b,
  output var logic addr10,
  output var logic odt
);
  // CK runs free at 200 ns, phase unrelated to the system clock
  initial begin
    {cke, cs_b, ras_b, cas_b, we_b, addr10, odt} = 7'h60;
    ck = 1'b0;
    #7;
    forever #100 ck = ~ck;
  end
  // Pins move at CK fall so they are stable around the rise
  task cmd(input logic [3:0] c, input logic a, input logic o, input logic k);
    @(negedge ck);
    {cs_b, ras_b, cas_b, we_b} = c;
    addr10 = a;
    odt = o;
    cke = k;
    @(negedge ck);
    cs_b = 1'b1;
    // Deselected lines do not keep their last value
    {ras_b, cas_b, we_b, addr10} = ~{ras_b, cas_b, we_b, addr10};
  endtask
  task idle(input int n);
    repeat (n) @(negedge ck);
  endtask
  // banks idle, CKE high, ODT low
  task zq(input logic lng);
    cmd(4'h6, lng, 1'b0, 1'b1);
  endtask
  // ODT held eight CK past the write, beyond ODTH8
  // and past the longest latency, so the on and off edges are timed apart
  task odt_write;
    cmd(4'hF, 1'b0, 1'b1, 1'b1);
    cmd(4'h4, 1'b0, 1'b1, 1'b1);
    idle(6);
    cmd(4'hF, 1'b0, 1'b0, 1'b1);
  endtask
endmodule // zqo_ctrl_model
`default_nettype wire

// ---- verification/zqo_core_tb.sv ----
// Self-checking bench for the ZQ calibration and termination block
`timescale 1ns/1ps
`default_nettype none
`include "zqo_defines.vh"
module zqo_core_tb;
  logic sys_clk, rst_b, clk_en, zq_cmp, reg_wr, reg_rd;
  logic [`ZQO_AW-1:0] reg_addr;
  logic [`ZQO_DW-1:0] reg_wdata;
  wire [`ZQO_DW-1:0] reg_rdata;
  wire [`ZQO_CODE_W-1:0] ron_code, rtt_code;
  wire [2:0] rtt_sel;
  wire ck, cke, cs_b, ras_b, cas_b, we_b, addr10, odt, term_on, zq_path_en, zq_busy;
  logic [31:0] rd_q[$], ev_q[$];
  logic rd_d = 1'b0, odt_q = 1'b0, term_d = 1'b0, busy_d = 1'b0;
  int num_errors = 0, comparisons = 0, odt_cnt = 0, zq_cnt = 0, i, cwl, al, nom, wrr;
  int w[3];
  zqo_ctrl_model zqo_ctrl_model_i (.ck, .cke, .cs_b, .ras_b, .cas_b, .we_b, .addr10, .odt);
  zqo_core zqo_core_i (.sys_clk, .rst_b, .clk_en, .ck, .cke, .cs_b, .ras_b, .cas_b,
    .we_b, .addr10, .odt, .zq_cmp, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .term_on, .rtt_sel, .ron_code, .rtt_code, .zq_path_en, .zq_busy);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One bus cycle; a read notes its expected data
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    if (r) rd_q.push_back(d);
    @(posedge sys_clk);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Watchdog; the sequence needs well under this
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end
  // CK rises since ODT last changed or a ZQ command was taken
  always @(posedge ck) begin
    odt_cnt <= (odt !== odt_q) ? 0 : odt_cnt + 1;
    odt_q <= odt;
    zq_cnt <= (!cs_b && ras_b && cas_b && !we_b) ? 0 : zq_cnt + 1;
  end
  // Results are matched against the oldest note
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    term_d <= term_on;
    busy_d <= zq_busy;
    if (rd_d) check("rdata", reg_rdata, rd_q.size() ? rd_q.pop_front() : 32'hX);
    if (term_on !== term_d) check("odt lat", odt_cnt, ev_q.size() ? ev_q.pop_front() : 32'hX);
    if (busy_d && !zq_busy) check("window", zq_cnt, ev_q.size() ? ev_q.pop_front() : 32'hX);
  end
  initial begin
    {rst_b, zq_cmp, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    zq_cmp = 1'b1;
    clk_en = 1'b1;
    void'($urandom(8));
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    // Reset values and an unmapped address
    bus(0, 1, `ZQO_ADDR_CFG, 32'h000020A0);
    bus(0, 1, `ZQO_ADDR_ZQINIT, `ZQO_RST_ZQINIT);
    bus(0, 1, `ZQO_ADDR_ZQOPER, `ZQO_RST_ZQOPER);
    bus(0, 1, `ZQO_ADDR_ZQCS, `ZQO_RST_ZQCS);
    bus(0, 1, 8'h18, 32'h0);
    for (i = 0; i < 3; i++) begin
      // At least two CK per window so the code takes a step
      w[i] = 2 + $urandom % 7;
      bus(1, 0, `ZQO_ADDR_ZQINIT + 8'(4 * i), w[i]);
    end
    bus(0, 0, 8'h00, 32'h0);
    $display("Test registers done");
    // first long, later long, then short
    for (i = 0; i < 3; i++) begin
      ev_q.push_back(w[i]);
      zqo_ctrl_model_i.zq(i < 2);
      check("busy path", {zq_busy, zq_path_en}, 2'b11);
      zqo_ctrl_model_i.idle(w[i] + 2);
      check("path off", zq_path_en, 1'b0);
      if (i == 0) check("ron step", ron_code > `ZQO_RST_CODE && rtt_code == ron_code, 1'b1);
      @(posedge sys_clk) zq_cmp <= $urandom;
    end
    $display("Test calibration done");
    bus(1, 0, `ZQO_ADDR_CFG, 32'h000020A1);
    bus(0, 0, 8'h00, 32'h0);
    zqo_ctrl_model_i.cmd(4'h1, 1'b0, 1'b0, 1'b0);
    zqo_ctrl_model_i.cmd(4'hF, 1'b0, 1'b1, 1'b0);
    zqo_ctrl_model_i.idle(12);
    check("sr term", term_on, 1'b0);
    zqo_ctrl_model_i.cmd(4'hF, 1'b0, 1'b0, 1'b1);
    zqo_ctrl_model_i.idle(12);
    check("sr exit busy", zq_busy, 1'b0);
    $display("Test self refresh done");
    // with CKE low the DLL counts as on only if power-down keeps it
    zqo_ctrl_model_i.cmd(4'hF, 1'b0, 1'b0, 1'b0);
    bus(1, 0, `ZQO_ADDR_CFG, 32'h000020A0);
    bus(0, 1, `ZQO_ADDR_STATUS, 32'h00000002);
    bus(1, 0, `ZQO_ADDR_CFG, 32'h000060A0);
    bus(0, 1, `ZQO_ADDR_STATUS, 32'h00000022);
    // DLL off with the nominal bits cleared keeps termination out
    bus(1, 0, `ZQO_ADDR_CFG, 32'h000000A0);
    bus(0, 1, `ZQO_ADDR_STATUS, 32'h00000002);
    bus(0, 0, 8'h00, 32'h0);
    zqo_ctrl_model_i.cmd(4'hF, 1'b0, 1'b0, 1'b1);
    // Clock enable low drops a write; the short window keeps its count
    clk_en <= 1'b0;
    bus(1, 0, `ZQO_ADDR_ZQCS, 32'h000000FF);
    clk_en <= 1'b1;
    bus(0, 1, `ZQO_ADDR_ZQCS, w[2]);
    bus(0, 0, 8'h00, 32'h0);
    $display("Test modes done");
    // Nominal only, write only, then none enabled
    for (i = 0; i < 3; i++) begin
      cwl = 5 + $urandom % 4;
      al = $urandom % 4;
      nom = (i == 0) ? 1 + $urandom % 7 : 0;
      wrr = (i == 1) ? 1 + $urandom % 3 : 0;
      bus(1, 0, `ZQO_ADDR_CFG, nom | wrr << 3 | cwl << 5 | al << 9 | 1 << 13);
      bus(0, 1, `ZQO_ADDR_CFG, nom | wrr << 3 | cwl << 5 | al << 9 | 1 << 13);
      bus(0, 0, 8'h00, 32'h0);
      if (i < 2) ev_q.push_back(cwl + al - 2);
      if (i < 2) ev_q.push_back(cwl + al - 2);
      zqo_ctrl_model_i.odt_write();
      zqo_ctrl_model_i.idle(cwl + al + 8);
      check("term end", term_on, 1'b0);
      check("rtt sel", rtt_sel, nom);
      check("all seen", ev_q.size(), 0);
    end
    $display("Test termination done");
    wrap_up();
  end
endmodule // zqo_core_tb
`default_nettype wire
